// file: design/swwd_top.sv
// Window watchdog, interrupt pin control and fault flags
`timescale 1ns/1ps
`include "swwd_cfg.svh"
module swwd_top
  import swwd_pkg::*;
#(
  parameter int CYCLES_PER_MS = `SWWD_CYC_PER_MS,
  parameter int PULSE_CYCLES  = `SWWD_RST_PULSE_CYC,
  parameter int DATA_W        = 16
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  input  wire logic              spiEnable,
  input  wire logic              rawSampleMode,
  input  wire logic              intEdgeMode,
  input  wire logic [1:0]        initialWindowSelect,
  input  wire logic              serviceMode,
  input  wire logic              sentConfig,
  input  wire logic              cmdValid,
  input  wire logic [1:0]        cmdCode,
  input  wire logic [5:0]        cmdAddr,
  input  wire logic [15:0]       cmdData,
  input  wire logic              sampleDone,
  input  wire logic              spiBusy,
  input  wire logic              hostReadDone,
  input  wire logic [DATA_W-1:0] positionIn,
  input  wire logic [DATA_W-1:0] ampAIn,
  input  wire logic [DATA_W-1:0] ampBIn,
  input  wire logic [15:0]       detFlags,
  input  wire logic              faultClear,
  input  wire logic              outDriverOn,
  input  wire logic              outDriveHigh,
  input  wire logic              outSenseHigh,
  input  wire logic              intPinIn,
  output logic                   intPinOut,
  output logic                   intPinOe,
  output logic [DATA_W-1:0]      positionWord,
  output logic [DATA_W-1:0]      receiverAmpA,
  output logic [DATA_W-1:0]      receiverAmpB,
  output logic [15:0]            faultFlagWord,
  output logic [8:0]             sentFaultBits,
  output logic [7:0]             sentFaultMsgId,
  output logic                   outPinHiZ,
  output logic                   outPinForceLow,
  output logic                   wdRunning
);

  localparam int PW = $clog2(PULSE_CYCLES + 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic swwd_ms_t initial_close(input logic [1:0] sel);
    case (sel)
      2'h1:    initial_close = `SWWD_INIT_WIN_1;
      2'h2:    initial_close = `SWWD_INIT_WIN_2;
      2'h3:    initial_close = `SWWD_INIT_WIN_3;
      default: initial_close = 8'h00;
    endcase
  endfunction

  // ****************************************
  // Interrupt pin
  // ****************************************
  logic              intPending;
  logic              pendAgain;
  logic              oeHist;
  logic              intPinError;
  logic [DATA_W-1:0] posLatch;
  logic              next_intPending;
  logic              next_pendAgain;
  logic              edgeBehave;
  logic              latchSample;
  logic              intErrEvent;

  assign edgeBehave  = intEdgeMode || rawSampleMode;                    // RULE1
  // Edge style keeps the data of the falling edge; level style tracks latest
  assign latchSample = sampleDone && (!intPending || !edgeBehave);      // RULE1
  // Level style re-asserts when a sample lands during a transfer
  assign next_pendAgain = hostReadDone ? 1'b0 :
                          (pendAgain || (sampleDone && intPending && spiBusy && !edgeBehave));
  assign next_intPending = hostReadDone ? (!edgeBehave && (pendAgain || sampleDone)) : // RULE22
                           (intPending || sampleDone);                                 // RULE22
  // One cycle of grace after release, as the pin rises through the pull-up
  assign intErrEvent = spiEnable && !intPinIn && !intPinOe && !oeHist; // RULE6 RULE7

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intPending <= 1'b0;
      pendAgain  <= 1'b0;
      intPinOe   <= 1'b0;
      intPinOut  <= 1'b0;
      oeHist     <= 1'b0;
    end else if (clkEn) begin
      intPending <= next_intPending;
      pendAgain  <= next_pendAgain;
      intPinOe   <= next_intPending; // RULE22
      intPinOut  <= 1'b0;
      oeHist     <= intPinOe;
    end
  end

  // ****************************************
  // Sample data
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      posLatch     <= '0;
      receiverAmpA <= '0;
      receiverAmpB <= '0;
      positionWord <= '0;
    end else if (clkEn) begin
      if (latchSample) begin
        posLatch     <= positionIn;
        receiverAmpA <= ampAIn; // RULE3
        receiverAmpB <= ampBIn; // RULE3
      end
      // Internal position is meaningless while raw samples are read out
      positionWord <= rawSampleMode ? '0 : (latchSample ? positionIn : posLatch); // RULE2
    end
  end

  // ****************************************
  // Fault flags
  // ****************************************
  logic        overdriveNow;
  logic [15:0] flagWordNow;
  logic        floatNow;

  assign overdriveNow = outDriverOn && (outDriveHigh != outSenseHigh); // RULE17

  swwd_fault_map u_fault_map (
    .detFlags    (detFlags),
    .intPinError (intPinError),
    .overdriven  (overdriveNow),
    .sentConfig  (sentConfig),
    .flagWord    (flagWordNow),
    .floatOut    (floatNow)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intPinError    <= 1'b0;
      faultFlagWord  <= `SWWD_FAULT_RESET;
      sentFaultBits  <= 9'h000;
      sentFaultMsgId <= `SWWD_SENT_MSG_ID;
      outPinHiZ      <= 1'b0;
    end else if (clkEn) begin
      // A new error in the clearing cycle survives the clear
      intPinError    <= intErrEvent || (intPinError && !faultClear); // RULE6
      faultFlagWord  <= flagWordNow;                                  // RULE15 RULE19
      sentFaultBits  <= flagWordNow[8:0];                             // RULE18
      sentFaultMsgId <= `SWWD_SENT_MSG_ID;                            // RULE18
      outPinHiZ      <= floatNow;                                     // RULE16
    end
  end

  // ****************************************
  // Watchdog decode
  // ****************************************
  swwd_state_e     state;
  swwd_state_e     next_state;
  swwd_ms_t        winOpen;
  swwd_ms_t        winClose;
  swwd_ms_t        msCount;
  logic [PW-1:0]   pulseCount;
  logic            msTick;
  logic            wdEnable;
  logic            refreshHit;
  swwd_ms_t        reqOpen;
  swwd_ms_t        reqClose;
  logic            reqInvalid;
  logic            isEarly;
  logic            isLate;
  logic            pulseDone;
  logic            loadInitial;
  logic            acceptRefresh;
  logic            countClear;

  assign wdEnable   = spiEnable && (initialWindowSelect != `SWWD_SEL_OFF) && !serviceMode; // RULE8 RULE10 RULE21
  assign refreshHit = cmdValid && (cmdCode == `SWWD_CMD_REFRESH)
                      && (cmdAddr == `SWWD_ADDR_REFRESH);                 // RULE11 RULE20
  assign reqClose   = cmdData[`SWWD_CLOSE_MSB:`SWWD_CLOSE_LSB];           // RULE20
  assign reqOpen    = cmdData[`SWWD_OPEN_MSB:`SWWD_OPEN_LSB];             // RULE20
  assign reqInvalid = (reqOpen == 8'h00) || (reqOpen >= reqClose);        // RULE14
  assign isEarly    = msCount < winOpen;                                  // RULE13 RULE23
  assign isLate     = msCount >= winClose;                                // RULE13 RULE23
  assign pulseDone  = (pulseCount == PW'(PULSE_CYCLES - 1));

  // ****************************************
  // Watchdog state machine
  // ****************************************
  // Reset, end of own pulse and service exit all pass through a reload
  always_comb begin
    next_state    = state;
    loadInitial   = 1'b0;
    acceptRefresh = 1'b0;
    case (state)
      WD_OFF: begin
        if (wdEnable) begin
          next_state  = WD_RUN;
          loadInitial = 1'b1; // RULE9
        end
      end
      WD_RUN: begin
        if (!wdEnable) begin
          next_state = WD_OFF; // RULE8 RULE10
        end else if (refreshHit) begin
          if (isEarly || reqInvalid) begin
            next_state = WD_PULSE; // RULE13 RULE14
          end else begin
            acceptRefresh = 1'b1; // RULE11
          end
        end else if (isLate) begin
          next_state = WD_PULSE; // RULE13
        end
      end
      WD_PULSE: begin
        if (pulseDone) begin
          next_state  = wdEnable ? WD_RUN : WD_OFF;
          loadInitial = wdEnable; // RULE9
        end
      end
      default: begin
        next_state = WD_OFF;
      end
    endcase
  end

  assign countClear = loadInitial || acceptRefresh;

  swwd_ms_tick #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_ms_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .clear   (countClear),
    .tick    (msTick)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= WD_OFF;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // ****************************************
  // Window registers and counters
  // ****************************************
  // Initial window has no early limit: any valid refresh before it closes counts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      winOpen  <= 8'h00;
      winClose <= 8'h00;
    end else if (clkEn) begin
      if (loadInitial) begin
        winOpen  <= 8'h00;                              // RULE9
        winClose <= initial_close(initialWindowSelect); // RULE9 RULE21
      end else if (acceptRefresh) begin
        winOpen  <= reqOpen;  // RULE11
        winClose <= reqClose; // RULE11
      end
    end
  end

  // Saturates so a stalled host still reads as late, never wraps to early
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msCount <= 8'h00;
    end else if (clkEn) begin
      if (countClear) begin
        msCount <= 8'h00; // RULE11
      end else if (msTick && state == WD_RUN && msCount != 8'hff) begin
        msCount <= msCount + 8'h01; // RULE23
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulseCount <= '0;
    end else if (clkEn) begin
      pulseCount <= (state == WD_PULSE && !pulseDone) ? pulseCount + PW'(1) : '0;
    end
  end

  // ****************************************
  // Watchdog outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outPinForceLow <= 1'b0;
      wdRunning      <= 1'b0;
    end else if (clkEn) begin
      outPinForceLow <= (next_state == WD_PULSE); // RULE13 RULE14
      wdRunning      <= (next_state == WD_RUN);
    end
  end

endmodule // swwd_top

// file: design/swwd_cfg.svh
// Constants of the window watchdog and fault flag block
// What this block and its host do
// RULE1: Raw-sample mode forces edge-style interrupt behaviour whatever the mode bit says.
// RULE2: Raw-sample mode holds the position output word at zero.
// RULE3: Raw-sample mode exposes both receiver amplitude words for host reads.
// RULE4: Host pairs amplitude samples by interrupt, never reads while interrupt is high.
// RULE5: Host should always drive raw-sample reads from the interrupt.
// RULE6: Interrupt pin low with no pending data sets fault bit 10.
// RULE7: Interrupt pin monitoring runs whenever the serial interface is enabled, any mode.
// RULE8: Watchdog runs only with serial interface enabled and nonzero window select.
// RULE9: Initial window reloads after reset, after own reset pulse, after service exit.
// RULE10: Watchdog is idle and raises nothing during service mode.
// RULE11: Valid refresh command 2 clears counter and stores new open/close times.
// RULE12: Host keeps refreshing inside the window set by the previous refresh.
// RULE13: Early refresh or missing refresh forces output pin low for pulse width.
// RULE14: Refresh with open zero or open not below close also forces the pulse.
// RULE15: Fault word bits 0 to 15 follow the fixed failure order.
// RULE16: Analog: all faults but bit 10 float the output; SENT: only bit 9, 11-15.
// RULE17: Output driver overdrive is detected in both configurations as bit 11.
// RULE18: Fault bits 8 to 0 go out in the SENT slow message with identifier 0x01.
// RULE19: Whole 16-bit fault word is readable in service and operating mode.
// RULE20: Refresh uses address 0x3F, close time in bits 15:8, open in 7:0.
// RULE21: Window select 0 disables; 1, 2, 3 give initial windows 5, 20, 200 ms.
// RULE22: Interrupt pin idles high, goes low at scan end, high after host read.
// RULE23: Watchdog counts milliseconds since last refresh against open and close times.
`ifndef SWWD_CFG_SVH
`define SWWD_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define SWWD_CLK_PERIOD_NS  8
`define SWWD_MS_NS          1000000
`define SWWD_CYC_PER_MS     (`SWWD_MS_NS / `SWWD_CLK_PERIOD_NS)
`define SWWD_RST_PULSE_NS   100000
`define SWWD_RST_PULSE_CYC  (`SWWD_RST_PULSE_NS / `SWWD_CLK_PERIOD_NS)

// ****************************************
// Refresh command and windows
// ****************************************
`define SWWD_CMD_REFRESH    2'h2
`define SWWD_ADDR_REFRESH   6'h3f
`define SWWD_CLOSE_MSB      15
`define SWWD_CLOSE_LSB      8
`define SWWD_OPEN_MSB       7
`define SWWD_OPEN_LSB       0
`define SWWD_INIT_WIN_1     8'h05
`define SWWD_INIT_WIN_2     8'h14
`define SWWD_INIT_WIN_3     8'hc8
`define SWWD_SEL_OFF        2'h0

// ****************************************
// Fault word
// ****************************************
`define SWWD_FAULT_INT_PIN  10
`define SWWD_FAULT_OVERDRV  11
`define SWWD_HIZ_MASK_ANA   16'hfbff
`define SWWD_HIZ_MASK_SENT  16'hfa00
`define SWWD_SENT_MSG_ID    8'h01
`define SWWD_FAULT_RESET    16'h0000

`endif

// file: design/swwd_pkg.sv
// Types of the window watchdog and fault flag block
package swwd_pkg;

  typedef enum logic [1:0] {
    WD_OFF,
    WD_RUN,
    WD_PULSE
  } swwd_state_e;

  typedef logic [7:0] swwd_ms_t;

endpackage

// file: design/swwd_ms_tick.sv
// Millisecond tick prescaler
`timescale 1ns/1ps
module swwd_ms_tick
  import swwd_pkg::*;
#(
  parameter int CYCLES_PER_MS = 125000
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  input  wire logic clear,
  output logic      tick
);

  localparam int CW = $clog2(CYCLES_PER_MS);

  logic [CW-1:0] preCount;
  logic          atEnd;

  assign atEnd = (preCount == CW'(CYCLES_PER_MS - 1));

  // ****************************************
  // Prescaler
  // ****************************************
  // Clear restarts the millisecond phase so a refresh starts a whole step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preCount <= '0;
      tick     <= 1'b0;
    end else if (clkEn) begin
      preCount <= (clear || atEnd) ? '0 : preCount + CW'(1); // RULE23
      tick     <= atEnd && !clear;
    end
  end

endmodule // swwd_ms_tick

// file: design/swwd_fault_map.sv
// Fault word assembly and output pin float decision
`timescale 1ns/1ps
`include "swwd_cfg.svh"
module swwd_fault_map
  import swwd_pkg::*;
(
  input  wire logic [15:0] detFlags,
  input  wire logic        intPinError,
  input  wire logic        overdriven,
  input  wire logic        sentConfig,
  output logic      [15:0] flagWord,
  output logic             floatOut
);

  logic [15:0] hizMask;

  // ****************************************
  // Word and float
  // ****************************************
  // Bits 10 and 11 come from this block's own monitors, not the detectors
  assign flagWord = {detFlags[15:12], overdriven, intPinError, detFlags[9:0]}; // RULE15 RULE17
  assign hizMask  = sentConfig ? `SWWD_HIZ_MASK_SENT : `SWWD_HIZ_MASK_ANA;    // RULE16
  assign floatOut = |(flagWord & hizMask);                                    // RULE16

endmodule // swwd_fault_map

// file: verification/swwd_properties.sv
// Port checker of the window watchdog and fault flag block
`timescale 1ns/1ps
module swwd_properties #(
  parameter int PULSE_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  input wire logic        spiEnable,
  input wire logic        rawSampleMode,
  input wire logic [1:0]  initialWindowSelect,
  input wire logic        serviceMode,
  input wire logic        sentConfig,
  input wire logic        cmdValid,
  input wire logic [1:0]  cmdCode,
  input wire logic [5:0]  cmdAddr,
  input wire logic [15:0] cmdData,
  input wire logic        sampleDone,
  input wire logic        hostReadDone,
  input wire logic [15:0] detFlags,
  input wire logic        faultClear,
  input wire logic        outDriverOn,
  input wire logic        outDriveHigh,
  input wire logic        outSenseHigh,
  input wire logic        intPinIn,
  input wire logic        intPinOe,
  input wire logic [15:0] positionWord,
  input wire logic [15:0] faultFlagWord,
  input wire logic [8:0]  sentFaultBits,
  input wire logic [7:0]  sentFaultMsgId,
  input wire logic        outPinHiZ,
  input wire logic        outPinForceLow,
  input wire logic        wdRunning
);
  // ****
  // Helpers
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] lowLen;
  wire         kick = clkEn && cmdValid && cmdCode == 2'h2 && cmdAddr == 6'h3f && wdRunning;
  // Counts pulse length so a long or short pulse shows at its fall
  always_ff @(posedge clk) begin
    if (sys_rst || !outPinForceLow) lowLen <= 16'h0000;
    else if (clkEn) lowLen <= lowLen + 16'h0001;
  end
  // ****
  // Properties
  // ****
  raw_pos_zero_a: assert property (rawSampleMode && clkEn ##1 rawSampleMode |-> positionWord == 16'h0000)
    else $error("position word not zero in raw mode");
  int_raise_a: assert property (clkEn && sampleDone && !intPinOe && !hostReadDone |=> intPinOe)
    else $error("interrupt not raised after sample");
  edge_release_a: assert property (clkEn && rawSampleMode && hostReadDone && !sampleDone |=> !intPinOe)
    else $error("interrupt held after read in raw mode");
  int_err_set_a: assert property (clkEn && spiEnable && !intPinIn && !intPinOe && !$past(intPinOe)
    ##1 (clkEn && !faultClear) [*2] |-> faultFlagWord[10])
    else $error("interrupt pin error not flagged");
  overdrive_a: assert property ((clkEn && outDriverOn && outDriveHigh != outSenseHigh) [*3]
    |-> faultFlagWord[11] && outPinHiZ)
    else $error("overdrive not flagged");
  hiz_analog_a: assert property ((clkEn && !sentConfig && (detFlags & 16'hf3ff) != 16'h0000) [*3] |-> outPinHiZ)
    else $error("analog output not floated");
  hiz_sent_a: assert property ((clkEn && sentConfig && !outDriverOn && (detFlags & 16'hf200) == 16'h0000) [*3]
    |-> !outPinHiZ)
    else $error("sent output floated");
  sent_msg_a: assert property (sentFaultMsgId == 8'h01 && sentFaultBits == faultFlagWord[8:0])
    else $error("sent fault message wrong");
  wd_off_a: assert property (clkEn && (serviceMode || !spiEnable || initialWindowSelect == 2'h0) |=> !wdRunning)
    else $error("watchdog running while disabled");
  bad_window_a: assert property (kick && (cmdData[7:0] == 8'h00 || cmdData[7:0] >= cmdData[15:8])
    |=> outPinForceLow)
    else $error("invalid window not punished");
  pulse_len_a: assert property ($fell(outPinForceLow) |-> lowLen == PULSE_CYCLES)
    else $error("reset pulse length wrong");
endmodule  // swwd_properties

// file: verification/swwd_host_model.sv
// Host microcontroller model on the serial side of the block
`timescale 1ns/1ps
module swwd_host_model (
  input  wire logic       clk,
  input  wire logic       intPinOe,
  input  wire logic [3:0] readLag,
  output logic            cmdValid,
  output logic [1:0]      cmdCode,
  output logic [5:0]      cmdAddr,
  output logic [15:0]     cmdData,
  output logic            spiBusy,
  output logic            hostReadDone
);
  logic [3:0] waited;
  initial begin
    cmdValid = 1'b0;
    cmdCode = 2'h0;
    cmdAddr = 6'h00;
    cmdData = 16'h0000;
    spiBusy = 1'b0;
    hostReadDone = 1'b0;
    waited = 4'h0;
  end
  // Reads only on a pending interrupt; long lag models a slow host
  wire reading = intPinOe && !hostReadDone;
  always @(posedge clk) begin
    hostReadDone <= reading && waited == readLag;
    spiBusy <= reading && waited != readLag;
    waited <= (reading && waited != readLag) ? waited + 4'h1 : 4'h0;
  end
  // Caller schedules each refresh, inside or outside the window of the previous one
  task automatic refresh(input logic [15:0] d);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= 2'h2;
    cmdAddr <= 6'h3f;
    cmdData <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdData <= ~d;
  endtask
endmodule  // swwd_host_model

// file: verification/swwd_top_bench.sv
// Self-checking bench of the window watchdog and fault flag block
`timescale 1ns/1ps
module swwd_top_bench;
  localparam int CPM = 10;
  localparam int PULSE = 4;
  logic clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, spiEnable = 1'b0, rawSampleMode = 1'b0, intEdgeMode = 1'b0;
  logic serviceMode = 1'b0, sentConfig = 1'b0, sampleDone = 1'b0, faultClear = 1'b0, extLow = 1'b0;
  logic outDriverOn = 1'b0, outDriveHigh = 1'b0, outSenseHigh = 1'b0;
  logic intPinOut, intPinOe, outPinHiZ, outPinForceLow, wdRunning, cmdValid, spiBusy, hostReadDone;
  logic [1:0]  initialWindowSelect = 2'h0, cmdCode;
  logic [5:0]  cmdAddr;
  logic [3:0]  readLag = 4'h2;
  logic [7:0]  sentFaultMsgId;
  logic [8:0]  sentFaultBits;
  logic [15:0] cmdData, positionWord, receiverAmpA, receiverAmpB, faultFlagWord, detFlags = 16'h0000;
  logic [15:0] positionIn = 16'h0000, ampAIn = 16'h0000, ampBIn = 16'h0000;
  wire         intPinIn = ~(intPinOe | extLow);
  int          nMismatch = 0, comparisons = 0, n;
  int          win[4] = '{0, 5, 20, 200};
  int          gap[5] = '{30, 5, 5, 5, 30};
  logic [15:0] kicks[5] = '{16'h0502, 16'h0502, 16'h0500, 16'h0303, 16'h0502};
  logic        bad[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  always #4 clk = ~clk;
  swwd_host_model host (.clk(clk), .intPinOe(intPinOe), .readLag(readLag), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .spiBusy(spiBusy), .hostReadDone(hostReadDone));
  swwd_top #(.CYCLES_PER_MS(CPM), .PULSE_CYCLES(PULSE)) dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .spiEnable(spiEnable), .rawSampleMode(rawSampleMode), .intEdgeMode(intEdgeMode),
    .initialWindowSelect(initialWindowSelect), .serviceMode(serviceMode), .sentConfig(sentConfig),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData), .sampleDone(sampleDone),
    .spiBusy(spiBusy), .hostReadDone(hostReadDone), .positionIn(positionIn), .ampAIn(ampAIn), .ampBIn(ampBIn),
    .detFlags(detFlags), .faultClear(faultClear), .outDriverOn(outDriverOn), .outDriveHigh(outDriveHigh),
    .outSenseHigh(outSenseHigh), .intPinIn(intPinIn), .intPinOut(intPinOut), .intPinOe(intPinOe),
    .positionWord(positionWord), .receiverAmpA(receiverAmpA), .receiverAmpB(receiverAmpB),
    .faultFlagWord(faultFlagWord), .sentFaultBits(sentFaultBits), .sentFaultMsgId(sentFaultMsgId),
    .outPinHiZ(outPinHiZ), .outPinForceLow(outPinForceLow), .wdRunning(wdRunning));
  // ****
  // Tasks
  // ****
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic sample(input logic [15:0] p, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    positionIn <= p;
    ampAIn <= a;
    ampBIn <= b;
    sampleDone <= 1'b1;
    @(posedge clk);
    sampleDone <= 1'b0;
    @(negedge clk);
  endtask
  // Bounded wait for the reset pulse; a missing required pulse ends the run
  task automatic waitLow(input int lim, input bit must, output int k);
    k = 0;
    while (outPinForceLow !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (must && k >= lim) begin
      check(16'h0001, 16'h0000);
      completeRun();
    end
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    step(12);
    sys_rst <= 1'b0;
    @(negedge clk);
    check(faultFlagWord, 16'h0000);
    check({8'h00, sentFaultMsgId}, 16'h0001);
    check({15'h0000, intPinOut}, 16'h0000);
    $display("reset test done");
    sample(16'h1234, 16'h0011, 16'h0022);
    check({15'h0000, intPinOe}, 16'h0001);
    check(positionWord, 16'h1234);
    sample(16'h4321, 16'h0011, 16'h0022);
    step(3);
    @(negedge clk);
    check({15'h0000, intPinOe}, 16'h0001);
    step(4);
    @(negedge clk);
    check({15'h0000, intPinOe}, 16'h0000);
    $display("level interrupt test done");
    @(posedge clk);
    rawSampleMode <= 1'b1;
    readLag <= 4'hf;
    sample(16'h1234, 16'h00a1, 16'h00b2);
    check(positionWord, 16'h0000);
    check(receiverAmpA, 16'h00a1);
    check(receiverAmpB, 16'h00b2);
    sample(16'h5678, 16'h00c3, 16'h00d4);
    check(receiverAmpA, 16'h00a1);
    step(20);
    @(negedge clk);
    check({15'h0000, intPinOe}, 16'h0000);
    @(posedge clk);
    rawSampleMode <= 1'b0;
    readLag <= 4'h2;
    $display("raw sample test done");
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      spiEnable <= 1'b1;
      intEdgeMode <= m[0];
      extLow <= 1'b1;
      @(posedge clk);
      extLow <= 1'b0;
      step(2);
      @(negedge clk);
      check(faultFlagWord, 16'h0400);
      check({15'h0000, outPinHiZ}, 16'h0000);
      check({15'h0000, wdRunning}, 16'h0000);
      @(posedge clk);
      faultClear <= 1'b1;
      @(posedge clk);
      faultClear <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check(faultFlagWord, 16'h0000);
    end
    $display("interrupt pin test done");
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 16; i++) begin
        if (i == 10 || i == 11) continue;
        @(posedge clk);
        sentConfig <= c[0];
        detFlags <= 16'h0001 << i;
        step(3);
        @(negedge clk);
        check(faultFlagWord, 16'h0001 << i);
        check({15'h0000, outPinHiZ}, {15'h0000, c == 0 || i == 9 || i > 11});
        check({7'h00, sentFaultBits}, (16'h0001 << i) & 16'h01ff);
      end
      @(posedge clk);
      detFlags <= 16'h0000;
      outDriverOn <= 1'b1;
      outDriveHigh <= 1'b1;
      step(3);
      @(negedge clk);
      check(faultFlagWord, 16'h0800);
      check({15'h0000, outPinHiZ}, 16'h0001);
      @(posedge clk);
      outDriverOn <= 1'b0;
    end
    step(3);
    $display("fault map test done");
    for (int s = 1; s < 4; s++) begin
      @(posedge clk);
      initialWindowSelect <= s[1:0];
      @(negedge clk);
      waitLow(2500, 1'b1, n);
      check({15'h0000, n >= win[s] * CPM - 2 && n <= win[s] * CPM + 6}, 16'h0001);
      @(posedge clk);
      initialWindowSelect <= 2'h0;
      step(8);
    end
    $display("initial window test done");
    @(posedge clk);
    initialWindowSelect <= 2'h3;
    for (int e = 0; e < 5; e++) begin
      step(gap[e]);
      host.refresh(kicks[e]);
      @(negedge clk);
      waitLow(10, 1'b0, n);
      check({15'h0000, n < 10}, {15'h0000, bad[e]});
      if (bad[e]) step(8);
    end
    waitLow(80, 1'b1, n);
    check({15'h0000, n >= 37 && n <= 45}, 16'h0001);
    step(8);
    $display("refresh test done");
    @(posedge clk);
    serviceMode <= 1'b1;
    host.refresh(16'h0000);
    @(negedge clk);
    waitLow(2100, 1'b0, n);
    check(n[15:0], 16'd2100);
    @(posedge clk);
    serviceMode <= 1'b0;
    step(3);
    @(negedge clk);
    check({15'h0000, wdRunning}, 16'h0001);
    $display("service mode test done");
    completeRun();
  end
  initial begin
    step(40000);
    check(16'h0001, 16'h0000);
    completeRun();
  end
endmodule  // swwd_top_bench

bind swwd_top swwd_properties #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
  .spiEnable(spiEnable), .rawSampleMode(rawSampleMode), .initialWindowSelect(initialWindowSelect),
  .serviceMode(serviceMode), .sentConfig(sentConfig), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
  .cmdData(cmdData), .sampleDone(sampleDone), .hostReadDone(hostReadDone), .detFlags(detFlags),
  .faultClear(faultClear), .outDriverOn(outDriverOn), .outDriveHigh(outDriveHigh), .outSenseHigh(outSenseHigh),
  .intPinIn(intPinIn), .intPinOe(intPinOe), .positionWord(positionWord), .faultFlagWord(faultFlagWord),
  .sentFaultBits(sentFaultBits), .sentFaultMsgId(sentFaultMsgId), .outPinHiZ(outPinHiZ),
  .outPinForceLow(outPinForceLow), .wdRunning(wdRunning));
